// ### hw/led_string_pkg.sv
// Constants and types for the four-string LED gate and fault control
//----------------------------------------------------------------------
// Operation
// - Single-input mode: string zero follows input directly
// - Strings one to three lag quarter periods
// - Four-input mode: each input gates its own string
// - Single-input mode: input zero drives all strings
// - Persistent short: gate off, fault output low
// - Faulty string never disturbs the other strings
// - Open string: step supply request upward first
// - Open verified only at maximum supply, unregulated
// - Verified open string leaves optimizer monitoring
// - After exclusion, recalibrate supply downward again
// - Fault output low while any verified fault
// - Enable toggle or fault read clears fault
// - Full scale 502mV, default 250mV sense level
// - Eight-bit common code, 0xff full, 0x7f half
//----------------------------------------------------------------------
package led_string_pkg;
   localparam int NUM_STR = 4;
   localparam int CLK_HZ = 10_000_000;
   localparam int HZ_PER_MHZ = 1_000_000;
   // Short must persist this long before the string is shut down
   localparam int SHORT_VERIFY_US = 10;
   localparam int SHORT_VERIFY_CYC = SHORT_VERIFY_US * (CLK_HZ / HZ_PER_MHZ);
   // Settling time between two supply request steps
   localparam int SUPPLY_STEP_US = 20;
   localparam int SUPPLY_STEP_CYC = SUPPLY_STEP_US * (CLK_HZ / HZ_PER_MHZ);
   // Edges from gate turn-on until the filtered sense input follows it
   localparam int SENSE_SETTLE_CYC = 4;
   localparam int FULL_SCALE_MV = 502;
   localparam int DEFAULT_SENSE_MV = 250;
   localparam logic [7:0] CODE_FULL = 8'hff;
   localparam logic [7:0] CODE_DEFAULT = 8'h7f;
   localparam logic [7:0] SUPPLY_MAX = 8'hff;
   localparam logic [7:0] SUPPLY_MIN = 8'h00;
   localparam logic [7:0] SUPPLY_ONE = 8'h01;

   typedef enum {ST_REGULATE, ST_CAL_DOWN} optimizer_state_e;

   // Pin inputs, all from outside the clock domain
   typedef struct packed {
      logic single_mode;
      logic enable;
      logic [NUM_STR-1:0] dim;
      logic [NUM_STR-1:0] short_det;
      logic [NUM_STR-1:0] regulating;
   } pin_in_s;

   // Latched fault record per string
   typedef struct packed {
      logic [NUM_STR-1:0] short_flt;
      logic [NUM_STR-1:0] open_flt;
   } fault_rec_s;
endpackage

// ### hw/led_string_gate_and_fault_ctl.sv
// Gate drive, phase shift, fault latching and supply optimizer control
`timescale 1ns/1ns
`default_nettype none
module led_string_gate_and_fault_ctl
#(
   parameter int PER_W = 20,
   parameter int SHORT_VERIFY_CYCLES = led_string_pkg::SHORT_VERIFY_CYC,
   parameter int STEP_CYCLES = led_string_pkg::SUPPLY_STEP_CYC
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire led_string_pkg::pin_in_s pins,
   input wire logic fault_read,
   input wire logic code_wr,
   input wire logic [7:0] code_data,
   output logic [led_string_pkg::NUM_STR-1:0] gate_drive,
   output logic fault_out_n_o,
   output logic fault_out_n_oe,
   output logic [7:0] supply_request,
   output logic [7:0] string_current_code,
   output led_string_pkg::fault_rec_s fault_record
);
   import led_string_pkg::*;

   //-------------------------------------------------------------------
   // Input synchronisers
   //-------------------------------------------------------------------
   pin_in_s s1_reg, s2_reg, s3_reg, pins_s;
   wire pin_in_s pins_next;
   // Change accepted once second and third stage agree
   assign pins_next = (s2_reg & s3_reg) | (pins_s & (s2_reg | s3_reg));

   // Three-stage chain; the agreement filter reads stages two and three
   always_ff @(posedge clk)
   begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (!rst_n)
         pins_s <= '0;
      else
         pins_s <= pins_next;
   end

   //-------------------------------------------------------------------
   // Dimming period measurement on input zero
   //-------------------------------------------------------------------
   logic dim0_prev_reg;
   logic [PER_W-1:0] phase_reg, period_reg, duty_reg;
   wire dim0_rise = pins_s.dim[0] & ~dim0_prev_reg;
   wire dim0_fall = ~pins_s.dim[0] & dim0_prev_reg;
   wire phase_sat = &phase_reg;
   wire [PER_W-1:0] quarter = period_reg >> 2;

   // Phase restarts on each rising edge; saturation marks a static input
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         dim0_prev_reg <= 1'b0;
         phase_reg <= '0;
         period_reg <= '0;
         duty_reg <= '0;
      end
      else
      begin
         dim0_prev_reg <= pins_s.dim[0];
         if (dim0_rise)
         begin
            phase_reg <= '0;
            period_reg <= phase_reg + PER_W'(1);
         end
         else if (!phase_sat)
            phase_reg <= phase_reg + PER_W'(1);
         if (dim0_fall)
            duty_reg <= phase_reg + PER_W'(1);
      end
   end

   //-------------------------------------------------------------------
   // Per-string dimming select, short verification and gate enable
   //-------------------------------------------------------------------
   fault_rec_s rec_reg;
   logic [NUM_STR-1:0] gate_reg;
   wire [NUM_STR-1:0] dim_sel;
   wire [NUM_STR-1:0] short_set;
   wire [NUM_STR-1:0] gate_next;
   wire [NUM_STR-1:0] settled;
   logic [NUM_STR-1:0] open_set;
   wire [NUM_STR-1:0] flt_any = rec_reg.short_flt | rec_reg.open_flt;
   // A fault set this cycle already blocks the next gate value
   wire [NUM_STR-1:0] gate_block = flt_any | short_set | open_set;

   genvar k;
   generate
      for (k = 0; k < NUM_STR; k++)
      begin : g_str
         logic [PER_W-1:0] short_cnt_reg;
         logic [2:0] settle_cnt_reg;
         wire [PER_W:0] lag = (PER_W+1)'(quarter) * (PER_W+1)'(k);
         // Phase restarts one edge after the filtered rise, hence the +1
         wire [PER_W:0] shifted = {1'b0, phase_reg} + {1'b0, period_reg}
            + (PER_W+1)'(1) - lag;
         wire [PER_W:0] wrapped = (shifted >= {1'b0, period_reg}) ?
            shifted - {1'b0, period_reg} : shifted;
         // Static input: a lagged copy of a constant is that constant
         wire lag_on = phase_sat ? pins_s.dim[0] :
            (wrapped < {1'b0, duty_reg});
         if (k == 0)
         begin : g_zero
            assign dim_sel[k] = pins_s.dim[0];
         end
         else
         begin : g_lag
            // Quarter-period offsets only in single-input mode
            assign dim_sel[k] = pins_s.single_mode ? lag_on
               : pins_s.dim[k];
         end
         wire shorting = gate_reg[k] & pins_s.short_det[k] &
            ~rec_reg.short_flt[k];
         assign short_set[k] = shorting &&
            (short_cnt_reg == PER_W'(SHORT_VERIFY_CYCLES - 1));
         // Faulted string held off; others depend only on own terms
         assign gate_next[k] = pins_s.enable & ~gate_block[k] &
            dim_sel[k];

         // Short must persist the whole verification time
         always_ff @(posedge clk)
         begin
            if (!rst_n || !shorting)
               short_cnt_reg <= '0;
            else if (!short_set[k])
               short_cnt_reg <= short_cnt_reg + PER_W'(1);
         end

         // Sense lags the gate by the filter; blank it until caught up
         assign settled[k] = (settle_cnt_reg == 3'(SENSE_SETTLE_CYC));
         always_ff @(posedge clk)
         begin
            if (!rst_n || !gate_reg[k])
               settle_cnt_reg <= '0;
            else if (!settled[k])
               settle_cnt_reg <= settle_cnt_reg + 3'(1);
         end
      end
   endgenerate

   //-------------------------------------------------------------------
   // Fault record and fault pin
   //-------------------------------------------------------------------
   wire fault_clear = ~pins_s.enable | fault_read;
   wire fault_rec_s rec_next;
   // New detection wins over a clear in the same cycle
   assign rec_next.short_flt = short_set |
      (rec_reg.short_flt & ~{NUM_STR{fault_clear}});
   assign rec_next.open_flt = open_set |
      (rec_reg.open_flt & ~{NUM_STR{fault_clear}});

   // Pin is pulled low one cycle after the record shows a fault
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rec_reg <= '0;
         gate_reg <= '0;
         fault_out_n_oe <= 1'b0;
      end
      else
      begin
         rec_reg <= rec_next;
         gate_reg <= gate_next;
         fault_out_n_oe <= |flt_any;
      end
   end
   assign fault_out_n_o = 1'b0;   // Open drain only ever sinks
   assign gate_drive = gate_reg;
   assign fault_record = rec_reg;

   //-------------------------------------------------------------------
   // Supply optimizer and current code
   //-------------------------------------------------------------------
   optimizer_state_e opt_state;
   logic [7:0] supply_reg, code_reg;
   logic [PER_W-1:0] step_cnt_reg;
   wire step_tick = (step_cnt_reg == PER_W'(STEP_CYCLES - 1));
   // Excluded strings no longer vote in supply decisions
   // Only settled strings count, else every turn-on looks unregulated
   wire [NUM_STR-1:0] unreg = settled & ~pins_s.regulating &
      ~rec_reg.open_flt;
   wire need_up = |unreg;
   wire at_max = (supply_reg == SUPPLY_MAX);
   assign open_set = (opt_state == ST_REGULATE && step_tick && at_max) ?
      unreg : '0;

   // Step up on lost regulation, step down while calibrating
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         opt_state <= ST_CAL_DOWN;
         supply_reg <= SUPPLY_MAX;
         step_cnt_reg <= '0;
         code_reg <= CODE_DEFAULT;
      end
      else
      begin
         step_cnt_reg <= step_tick ? '0 : step_cnt_reg + PER_W'(1);
         if (code_wr)
            code_reg <= code_data;
         case (opt_state)
            ST_REGULATE:
               if (|open_set)
                  opt_state <= ST_CAL_DOWN;
               else if (step_tick && need_up)
                  supply_reg <= supply_reg + SUPPLY_ONE;
            ST_CAL_DOWN:
               if (step_tick)
               begin
                  if (need_up)
                  begin
                     opt_state <= ST_REGULATE;
                     if (!at_max)
                        supply_reg <= supply_reg + SUPPLY_ONE;
                  end
                  else if (supply_reg == SUPPLY_MIN)
                     opt_state <= ST_REGULATE;
                  else
                     supply_reg <= supply_reg - SUPPLY_ONE;
               end
            default:
               opt_state <= ST_REGULATE;
         endcase
      end
   end
   assign supply_request = supply_reg;
   assign string_current_code = code_reg;

   //-------------------------------------------------------------------
   // Assertions
   //-------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_zero_follows_input: assert property (
      (pins_s.enable && !gate_block[0])
      |=> gate_reg[0] == $past(pins_s.dim[0]))
      else $error("string zero does not follow input zero");
   a_own_input_gates: assert property (
      (!pins_s.single_mode && pins_s.enable && !gate_block[1])
      |=> gate_reg[1] == $past(pins_s.dim[1]))
      else $error("string one not gated by its own input");
   a_short_gate_off: assert property (
      $rose(rec_reg.short_flt[0]) |-> !gate_reg[0] ##1 fault_out_n_oe)
      else $error("shorted string still driven or pin not low");
   a_other_string_runs: assert property (
      (rec_reg.short_flt[0] && pins_s.enable && !gate_block[2] &&
       !pins_s.single_mode) |=> gate_reg[2] == $past(pins_s.dim[2]))
      else $error("healthy string disturbed by fault on another");
   a_step_up_supply: assert property (
      (opt_state == ST_REGULATE && step_tick && need_up && !at_max)
      |=> supply_reg == $past(supply_reg) + SUPPLY_ONE)
      else $error("supply request did not step up");
   a_open_at_max: assert property (
      ((rec_reg.open_flt & ~$past(rec_reg.open_flt)) != '0)
      |-> $past(supply_reg == SUPPLY_MAX))
      else $error("open fault declared below maximum supply");
   a_recal_after_open: assert property (
      $rose(|rec_reg.open_flt) |-> opt_state == ST_CAL_DOWN)
      else $error("no calibration cycle after open fault");
   a_fault_pin_hold: assert property (
      (|flt_any) |=> fault_out_n_oe)
      else $error("fault pin released while fault latched");
   a_read_clears: assert property (
      (fault_read && short_set == '0 && open_set == '0)
      |=> ##1 !fault_out_n_oe)
      else $error("fault read did not release fault pin");
   a_faulted_stays_off: assert property (
      (flt_any != '0) |=> (gate_reg & $past(flt_any)) == '0)
      else $error("faulted string driven again");
   a_code_load: assert property (
      code_wr |=> code_reg == $past(code_data))
      else $error("current code not loaded");
endmodule
`default_nettype wire

// ### tb/led_string_sink_model.sv
// Behavioural model of the external sink transistors and LED strings
`timescale 1ns/1ns
`default_nettype none
module led_string_sink_model
(
   input wire logic [3:0] gate_drive,
   input wire logic [3:0] shorted,
   input wire logic [3:0] opened,
   output logic [3:0] short_det,
   output logic [3:0] regulating
);
   //-------------------------------------------------------------------
   // Sense comparators
   //-------------------------------------------------------------------
   // A shorted string only shows high drain voltage while it conducts
   assign short_det = gate_drive & shorted;
   // An open string never reaches its current target, even at full supply
   assign regulating = gate_drive & ~opened;
endmodule
`default_nettype wire

// ### tb/test_led_string_gate_and_fault_ctl.sv
// Self-checking bench for the LED gate and fault control block
`timescale 1ns/1ns
`default_nettype none
module test_led_string_gate_and_fault_ctl;
   import led_string_pkg::*;
   logic clk = 0, rst_n = 0, single_mode = 0, enable = 1;
   logic fault_read = 0, code_wr = 0;
   logic [7:0] code_data = 8'h00, supply_was;
   logic [3:0] dim = 4'h0, shorted = 4'h0, opened = 4'h0;
   logic [3:0] short_det, regulating, gate_drive;
   logic fault_out_n_o, fault_out_n_oe, fault_pin;
   logic [7:0] supply_request, string_current_code;
   fault_rec_s fault_record;
   pin_in_s pins;
   int num_errors = 0, n_tests = 0, i, p, c;
   logic [3:0] rows [5] = '{4'h1, 4'h2, 4'ha, 4'h0, 4'hf};

   assign pins = '{single_mode, enable, dim, short_det, regulating};
   // Open-drain line with pull-up
   assign fault_pin = fault_out_n_oe ? fault_out_n_o : 1'b1;

   led_string_gate_and_fault_ctl #(.SHORT_VERIFY_CYCLES(4),
      .STEP_CYCLES(4)) DUT (.clk(clk), .rst_n(rst_n), .pins(pins),
      .fault_read(fault_read), .code_wr(code_wr), .code_data(code_data),
      .gate_drive(gate_drive), .fault_out_n_o(fault_out_n_o),
      .fault_out_n_oe(fault_out_n_oe), .supply_request(supply_request),
      .string_current_code(string_current_code),
      .fault_record(fault_record));
   led_string_sink_model sink (.gate_drive(gate_drive), .shorted(shorted),
      .opened(opened), .short_det(short_det), .regulating(regulating));

   //-------------------------------------------------------------------
   // Clock and watchdog
   //-------------------------------------------------------------------
   initial
   begin
      forever #50 clk = ~clk;
   end
   // Whole run needs about 2500 cycles; allow eight times that
   initial
   begin
      #2000000;
      num_errors++;
      summarize();
   end

   //-------------------------------------------------------------------
   // Helpers
   //-------------------------------------------------------------------
   // Inputs move 10 ns after the rising edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp,
      input string msg);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR %0t %s got %h want %h", $time, msg, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   //-------------------------------------------------------------------
   // Main sequence
   //-------------------------------------------------------------------
   initial
   begin
      cyc(3);
      rst_n = 1;
      check(string_current_code, 8'h7f, "default code");
      check(supply_request, 8'hff, "supply reset");
      check({fault_pin, gate_drive, 3'h0}, 8'h80, "pin and gates idle");
      check(fault_record, 8'h00, "record reset");
      code_wr = 1;
      code_data = 8'hff;
      cyc(1);
      code_wr = 0;
      check(string_current_code, 8'hff, "code load");
      // Four-input table, each input gates only its own string
      for (i = 0; i < 5; i++)
      begin
         dim = rows[i];
         cyc(6);
         check(gate_drive, rows[i], "own string gate");
      end
      // Persistent short on string zero
      shorted = 4'h1;
      cyc(14);
      check(gate_drive, 4'he, "short shut down");
      check(fault_pin, 1'b0, "fault pin short");
      check(fault_record, 8'h10, "short record");
      dim = 4'he;
      cyc(6);
      dim = 4'hf;
      shorted = 4'h0;
      cyc(6);
      check(gate_drive, 4'he, "faulted stays off");
      fault_read = 1;
      cyc(1);
      fault_read = 0;
      cyc(3);
      check(fault_record, 8'h00, "read clears record");
      check(fault_pin, 1'b1, "read clears pin");
      check(gate_drive, 4'hf, "string back");
      // Open string one: supply climbs, then fault, then recalibration
      cyc(1100);
      supply_was = supply_request;
      opened = 4'h2;
      cyc(24);
      check(supply_request > supply_was, 1'b1, "supply steps up");
      for (i = 0; i < 2000 && fault_record.open_flt[1] !== 1'b1; i++)
         cyc(1);
      check(fault_record, 8'h02, "open record");
      check(supply_request, 8'hff, "open at max");
      cyc(40);
      check(supply_request < 8'hff, 1'b1, "recalibrate");
      check(fault_pin, 1'b0, "fault pin open");
      enable = 0;
      cyc(6);
      check({fault_pin, gate_drive, 3'h0}, 8'h80, "enable off");
      check(fault_record, 8'h00, "enable clears");
      enable = 1;
      opened = 4'h0;
      // Single input, period 40 cycles, duty 10: quarter-phase strings
      single_mode = 1;
      for (p = 0; p < 4; p++)
         for (c = 0; c < 40; c++)
         begin
            // The middle cycle of each quarter, the first of each gate window, catches a one-cycle late phase skew; the last falls mid-window
            if (p == 3 && (c % 10 == 5 || c % 10 == 9))
               check(gate_drive, 4'h1 << (c / 10),
                  "phase");
            dim = {3'h0, c < 10};
            cyc(1);
         end
      summarize();
   end
endmodule
`default_nettype wire
